/* frc_pkg.sv */
// Package: register map, field positions and reset values of the flash rewrite control block
package frc_pkg;
	// =====================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;

	// =====================================================
	// Control register fields
	localparam int CTRL_W        = 8;
	localparam int BIT_READY     = 0;
	localparam int BIT_REWRITE   = 1;
	localparam int BIT_LOCK_OVR  = 2;
	localparam int BIT_SEQ_RST   = 3;
	localparam int BIT_RESERVED  = 4;
	localparam int BIT_AREA_SEL  = 5;

	// =====================================================
	// Interrupt status fields
	localparam int IRQ_W         = 3;
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_ENTERED   = 1;
	localparam int IRQ_REFUSED   = 2;

	// =====================================================
	// Reset values
	localparam logic             RST_FLAG  = 1'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ   = 3'h0;
	localparam logic [31:0]      RST_RDATA = 32'h0;
endpackage

/* frc_seq_arm.sv */
// Two-write arming detector: a 0 write followed directly by a 1 write
module frc_seq_arm (
	input  wire logic clk_sys_i,
	input  wire logic reset_n_i,
	input  wire logic wr_i,
	input  wire logic bit_i,
	input  wire logic abort_i,
	input  wire logic allow_i,
	output logic      set_o
);
	logic armed;
	logic next_armed;

	// =====================================================
	// Arming
	always_comb begin
		next_armed = armed;
		set_o      = 1'b0;
		if (abort_i || !allow_i) begin
			// Interrupt or DMA between the two writes breaks the pair
			next_armed = 1'b0;
		end else if (wr_i) begin
			set_o      = bit_i && armed;
			next_armed = !bit_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			armed <= frc_pkg::RST_FLAG;
		end else begin
			armed <= next_armed;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	set_needs_arm_a: assert property (set_o |-> $past(wr_i && !bit_i && allow_i) || $past(armed))
		else $error("set without preceding zero write");
	abort_disarms_a: assert property (abort_i |=> !set_o)
		else $error("set right after abort");
endmodule

/* frc_flash_ctrl.sv */
// Flash rewrite control register with Avalon-MM slave and interrupt
module frc_flash_ctrl (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic [7:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [3:0]  byteenable_i,
	input  wire logic [31:0] writedata_i,
	output logic [31:0]      readdata_o,
	output logic             waitrequest_o,
	input  wire logic        flash_busy_i,
	input  wire logic        boot_mode_i,
	input  wire logic        irq_taken_i,
	input  wire logic        dma_xfer_i,
	output logic             cmd_accept_o,
	output logic             lock_override_o,
	output logic             seq_reset_o,
	output logic             user_area_o,
	output logic             irq_o
);
	logic                       ack;
	logic                       next_ack;
	logic [31:0]                rdata;
	logic [31:0]                next_rdata;
	logic                       boot_meta;
	logic                       boot_sync;
	logic                       busy_q;
	logic                       rewrite_en;
	logic                       next_rewrite_en;
	logic                       lock_ovr;
	logic                       next_lock_ovr;
	logic                       seq_rst;
	logic                       next_seq_rst;
	logic                       area_sel;
	logic                       next_area_sel;
	logic                       area_route;
	logic                       next_area_route;
	logic [frc_pkg::IRQ_W-1:0]  irq_stat;
	logic [frc_pkg::IRQ_W-1:0]  next_irq_stat;
	logic [frc_pkg::IRQ_W-1:0]  irq_mask;
	logic [frc_pkg::IRQ_W-1:0]  next_irq_mask;
	logic [frc_pkg::IRQ_W-1:0]  irq_event;
	logic                       wr_ok;
	logic                       ctrl_wr;
	logic [frc_pkg::CTRL_W-1:0] wd;
	logic                       abort;
	logic                       rew_set;
	logic                       lock_set;
	logic [frc_pkg::CTRL_W-1:0] ctrl_view;

	// =====================================================
	// Boot mode strap synchroniser
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_meta <= frc_pkg::RST_FLAG;
			boot_sync <= frc_pkg::RST_FLAG;
		end else begin
			boot_meta <= boot_mode_i;
			boot_sync <= boot_meta;
		end
	end

	// =====================================================
	// Bus slave: one wait state, write at the released edge, read data captured at the first edge
	assign waitrequest_o = (read_i || write_i) && !ack;
	assign wr_ok         = write_i && ack;
	assign wd            = writedata_i[frc_pkg::CTRL_W-1:0];
	assign ctrl_wr       = wr_ok && (address_i == frc_pkg::ADDR_CTRL) && byteenable_i[0];
	assign abort         = irq_taken_i || dma_xfer_i;

	always_comb begin
		ctrl_view                         = '0;
		ctrl_view[frc_pkg::BIT_READY]     = !flash_busy_i;
		ctrl_view[frc_pkg::BIT_REWRITE]   = rewrite_en;
		ctrl_view[frc_pkg::BIT_LOCK_OVR]  = lock_ovr;
		ctrl_view[frc_pkg::BIT_SEQ_RST]   = seq_rst;
		ctrl_view[frc_pkg::BIT_RESERVED]  = 1'b0;
		ctrl_view[frc_pkg::BIT_AREA_SEL]  = area_sel;
		// Unassigned top bits are undefined; zero is a legal value
		next_ack   = (read_i || write_i) && !ack;
		next_rdata = rdata;
		if (read_i && !ack) begin
			case (address_i)
				frc_pkg::ADDR_CTRL:     next_rdata = {24'h0, ctrl_view};
				frc_pkg::ADDR_IRQ_STAT: next_rdata = {29'h0, irq_stat};
				frc_pkg::ADDR_IRQ_MASK: next_rdata = {29'h0, irq_mask};
				default:                next_rdata = frc_pkg::RST_RDATA;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack   <= frc_pkg::RST_FLAG;
			rdata <= frc_pkg::RST_RDATA;
		end else begin
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end
	assign readdata_o = rdata;

	// =====================================================
	// Write-pair detectors
	frc_seq_arm u_rew_arm (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_i      (ctrl_wr),
		.bit_i     (wd[frc_pkg::BIT_REWRITE]),
		.abort_i   (abort),
		.allow_i   (1'b1),
		.set_o     (rew_set)
	);

	frc_seq_arm u_lock_arm (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_i      (ctrl_wr),
		.bit_i     (wd[frc_pkg::BIT_LOCK_OVR]),
		.abort_i   (abort),
		.allow_i   (rewrite_en),
		.set_o     (lock_set)
	);

	// =====================================================
	// Control bits
	always_comb begin
		next_rewrite_en = rewrite_en;
		if (ctrl_wr && !wd[frc_pkg::BIT_REWRITE]) begin
			next_rewrite_en = 1'b0;
		end else if (rew_set) begin
			next_rewrite_en = 1'b1;
		end
		next_lock_ovr = lock_ovr;
		if (!next_rewrite_en) begin
			next_lock_ovr = 1'b0;
		end else if (ctrl_wr && !wd[frc_pkg::BIT_LOCK_OVR]) begin
			next_lock_ovr = 1'b0;
		end else if (lock_set) begin
			next_lock_ovr = 1'b1;
		end
		// Reset bit only writable and held inside rewrite mode
		next_seq_rst = seq_rst;
		if (!next_rewrite_en) begin
			next_seq_rst = 1'b0;
		end else if (ctrl_wr && rewrite_en) begin
			next_seq_rst = wd[frc_pkg::BIT_SEQ_RST];
		end
		next_area_sel = ctrl_wr ? wd[frc_pkg::BIT_AREA_SEL] : area_sel;
		next_area_route = next_area_sel && boot_sync;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rewrite_en <= frc_pkg::RST_FLAG;
			lock_ovr   <= frc_pkg::RST_FLAG;
			seq_rst    <= frc_pkg::RST_FLAG;
			area_sel   <= frc_pkg::RST_FLAG;
			area_route <= frc_pkg::RST_FLAG;
		end else begin
			rewrite_en <= next_rewrite_en;
			lock_ovr   <= next_lock_ovr;
			seq_rst    <= next_seq_rst;
			area_sel   <= next_area_sel;
			area_route <= next_area_route;
		end
	end

	assign cmd_accept_o    = rewrite_en;
	assign lock_override_o = lock_ovr;
	assign seq_reset_o     = seq_rst;
	assign user_area_o     = area_route;

	// =====================================================
	// Interrupt status, mask and output
	always_comb begin
		irq_event                       = '0;
		irq_event[frc_pkg::IRQ_DONE]    = busy_q && !flash_busy_i;
		irq_event[frc_pkg::IRQ_ENTERED] = rew_set && !rewrite_en;
		irq_event[frc_pkg::IRQ_REFUSED] = ctrl_wr && ((wd[frc_pkg::BIT_REWRITE] && !rewrite_en && !rew_set) ||
			(wd[frc_pkg::BIT_LOCK_OVR] && !lock_ovr && !lock_set));
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		if (wr_ok && byteenable_i[0] && address_i == frc_pkg::ADDR_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~writedata_i[frc_pkg::IRQ_W-1:0];
		end
		if (wr_ok && byteenable_i[0] && address_i == frc_pkg::ADDR_IRQ_MASK) begin
			next_irq_mask = writedata_i[frc_pkg::IRQ_W-1:0];
		end
		// Set wins over a same-cycle clear
		next_irq_stat = next_irq_stat | irq_event;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_q   <= frc_pkg::RST_FLAG;
			irq_stat <= frc_pkg::RST_IRQ;
			irq_mask <= frc_pkg::RST_IRQ;
		end else begin
			busy_q   <= flash_busy_i;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
		end
	end
	assign irq_o = |(irq_stat & irq_mask);

	// =====================================================
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	seq_reset_gate_a: assert property (seq_reset_o |-> cmd_accept_o)
		else $error("sequencer reset outside rewrite mode");
	seq_reset_release_a: assert property (ctrl_wr && rewrite_en && !wd[frc_pkg::BIT_SEQ_RST] |=> !seq_reset_o)
		else $error("sequencer reset not released");
	area_boot_only_a: assert property (##2 !boot_sync |=> !user_area_o)
		else $error("area select active outside boot mode");
	reserved_zero_a: assert property (ack && read_i && address_i == frc_pkg::ADDR_CTRL
		|-> !readdata_o[frc_pkg::BIT_RESERVED])
		else $error("reserved bit read as one");
	rewrite_rise_a: assert property ($rose(cmd_accept_o) |-> $past(ctrl_wr && wd[frc_pkg::BIT_REWRITE] && !abort))
		else $error("rewrite mode set without write pair");
	// Control writes are never back to back, so an abort now or one cycle ago breaks the pair
	single_write_a: assert property (!rewrite_en && ctrl_wr && wd[frc_pkg::BIT_REWRITE]
		&& (abort || $past(abort)) |=> !rewrite_en)
		else $error("rewrite mode set by single write");
	lock_in_mode_a: assert property (lock_override_o |-> cmd_accept_o)
		else $error("lock override outside rewrite mode");
	lock_rise_a: assert property ($rose(lock_override_o) |-> $past(rewrite_en && lock_set))
		else $error("lock override set without pair");
	ready_flag_a: assert property (ack && read_i && address_i == frc_pkg::ADDR_CTRL
		|-> readdata_o[frc_pkg::BIT_READY] == !$past(flash_busy_i))
		else $error("ready flag wrong");
	bus_wait_a: assert property ((read_i || write_i) && !ack |-> waitrequest_o ##1 (!(read_i || write_i) || !waitrequest_o))
		else $error("bus answer not after one wait");
	irq_level_a: assert property ($past(|(next_irq_stat & next_irq_mask)) |-> irq_o)
		else $error("interrupt not raised");

	enter_c: cover property ($rose(cmd_accept_o));
	lock_c:  cover property ($rose(lock_override_o));
	rst_c:   cover property (seq_reset_o ##[1:20] !seq_reset_o);
	irq_c:   cover property ($rose(irq_o));
endmodule

/* tb_flash_rewrite_control_bits.sv */
// Self-checking testbench for the flash rewrite control block
module tb_flash_rewrite_control_bits;
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// Ports and bookkeeping
	typedef struct {logic rd; logic [7:0] a; logic [7:0] d;} frc_tb_row_t;
	logic        clk_sys_i     = 1'b0;
	logic        reset_n_i     = 1'b0;
	logic [7:0]  address_i     = 8'h00;
	logic        read_i        = 1'b0;
	logic        write_i       = 1'b0;
	logic [3:0]  byteenable_i  = 4'hf;
	logic [31:0] writedata_i   = 32'h0;
	logic        flash_busy_i  = 1'b0;
	logic        boot_mode_i   = 1'b0;
	logic        irq_taken_i   = 1'b0;
	logic        dma_xfer_i    = 1'b0;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic        cmd_accept_o;
	logic        lock_override_o;
	logic        seq_reset_o;
	logic        user_area_o;
	logic        irq_o;
	logic        wait_pre;
	logic [31:0] rd_pre;
	logic [31:0] q;
	int          bad_count     = 0;
	int          check_count   = 0;
	frc_tb_row_t rows [17] = '{
		'{1'b1, 8'h00, 8'h01}, '{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h00, 8'h02}, '{1'b1, 8'h00, 8'h03},
		'{1'b0, 8'h00, 8'h02}, '{1'b0, 8'h00, 8'h06}, '{1'b1, 8'h00, 8'h07}, '{1'b0, 8'h00, 8'h0e},
		'{1'b1, 8'h00, 8'h0f}, '{1'b0, 8'h00, 8'h06}, '{1'b1, 8'h00, 8'h07}, '{1'b0, 8'h00, 8'h00},
		'{1'b1, 8'h00, 8'h01}, '{1'b0, 8'h00, 8'h08}, '{1'b1, 8'h00, 8'h01}, '{1'b1, 8'h0c, 8'h00},
		'{1'b1, 8'h00, 8'h01}};

	always #2 clk_sys_i = ~clk_sys_i;

	// Sampled mid-cycle so the rising edge sees settled values, free of races
	always @(negedge clk_sys_i) begin
		wait_pre <= waitrequest_o;
		rd_pre <= readdata_o;
	end

	frc_flash_ctrl u_frc_flash_ctrl (
		.clk_sys_i       (clk_sys_i),
		.reset_n_i       (reset_n_i),
		.address_i       (address_i),
		.read_i          (read_i),
		.write_i         (write_i),
		.byteenable_i    (byteenable_i),
		.writedata_i     (writedata_i),
		.readdata_o      (readdata_o),
		.waitrequest_o   (waitrequest_o),
		.flash_busy_i    (flash_busy_i),
		.boot_mode_i     (boot_mode_i),
		.irq_taken_i     (irq_taken_i),
		.dma_xfer_i      (dma_xfer_i),
		.cmd_accept_o    (cmd_accept_o),
		.lock_override_o (lock_override_o),
		.seq_reset_o     (seq_reset_o),
		.user_area_o     (user_area_o),
		.irq_o           (irq_o)
	);

	// =====================================================
	// Shared tasks
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One Avalon transfer; idle cycle first so strobes never change twice in a step
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		address_i <= a;
		writedata_i <= {24'h0, d};
		write_i <= wr;
		read_i <= ~wr;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wait_pre !== 1'b0 && n < 50);
		q = rd_pre;
		write_i <= 1'b0;
		read_i <= 1'b0;
		chk("bus answer", {31'h0, n < 50}, 32'h1);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// =====================================================
	// Watchdog, far above the expected run length
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end

	// =====================================================
	// Main sequence
	initial begin
		cyc(12);
		reset_n_i <= 1'b1;
		chk("outputs in reset", {cmd_accept_o, lock_override_o, seq_reset_o, user_area_o, irq_o}, 32'h0);
		foreach (rows[i]) begin
			bus(~rows[i].rd, rows[i].a, rows[i].d);
			if (rows[i].rd)
				chk("row read", {26'h0, q[5:0]}, {26'h0, rows[i].d[5:0]});
		end
		$display("table rows done");
		// Clear pending status by writing ones
		bus(1'b1, 8'h04, 8'h07);
		bus(1'b0, 8'h04, 8'h00);
		chk("status after clear", q[2:0], 32'h0);
		// A stray interrupt or DMA cycle between the two writes breaks the pair
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 8'h00, 8'h00);
			@(posedge clk_sys_i);
			if (k == 0) dma_xfer_i <= 1'b1;
			else irq_taken_i <= 1'b1;
			@(posedge clk_sys_i);
			dma_xfer_i <= 1'b0;
			// Interrupt held through the one write, so it also overlaps its take edge
			bus(1'b1, 8'h00, 8'h02);
			irq_taken_i <= 1'b0;
			cyc(1);
			chk("broken pair", {31'h0, cmd_accept_o}, 32'h0);
		end
		bus(1'b1, 8'h00, 8'h04);
		cyc(1);
		chk("lock pair outside rewrite", {31'h0, lock_override_o}, 32'h0);
		bus(1'b0, 8'h04, 8'h00);
		chk("refused status", q[2], 32'h1);
		bus(1'b1, 8'h08, 8'h04);
		bus(1'b0, 8'h08, 8'h00);
		chk("mask readback", q[2:0], 32'h4);
		cyc(1);
		chk("irq raised", {31'h0, irq_o}, 32'h1);
		bus(1'b1, 8'h04, 8'h04);
		cyc(1);
		chk("irq cleared", {31'h0, irq_o}, 32'h0);
		$display("pair break and interrupt done");
		// Lock override follows rewrite mode out
		bus(1'b1, 8'h00, 8'h00);
		bus(1'b1, 8'h00, 8'h02);
		// Lock pair needs its zero write inside rewrite mode
		bus(1'b1, 8'h00, 8'h02);
		bus(1'b1, 8'h00, 8'h06);
		bus(1'b1, 8'h00, 8'h0e);
		cyc(1);
		chk("mode outputs", {cmd_accept_o, lock_override_o, seq_reset_o}, 32'h7);
		bus(1'b1, 8'h00, 8'h00);
		cyc(1);
		chk("mode left", {cmd_accept_o, lock_override_o, seq_reset_o}, 32'h0);
		// Busy flag and completion event
		flash_busy_i <= 1'b1;
		cyc(2);
		bus(1'b0, 8'h00, 8'h00);
		chk("busy read", q[0], 32'h0);
		flash_busy_i <= 1'b0;
		cyc(3);
		bus(1'b0, 8'h04, 8'h00);
		// Flash done plus rewrite entered from the lock scenario
		chk("done status", q[2:0], 32'h3);
		// Area select steers only in boot mode
		bus(1'b1, 8'h00, 8'h20);
		cyc(5);
		chk("area outside boot", {31'h0, user_area_o}, 32'h0);
		boot_mode_i <= 1'b1;
		cyc(5);
		chk("area in boot", {31'h0, user_area_o}, 32'h1);
		bus(1'b1, 8'h00, 8'h00);
		cyc(1);
		chk("boot area chosen", {31'h0, user_area_o}, 32'h0);
		$display("mode, busy and area done");
		// Reset in mid-run drops rewrite mode
		bus(1'b1, 8'h00, 8'h00);
		bus(1'b1, 8'h00, 8'h02);
		@(posedge clk_sys_i);
		reset_n_i <= 1'b0;
		cyc(2);
		chk("mid-run reset", {cmd_accept_o, lock_override_o, seq_reset_o, user_area_o, irq_o}, 32'h0);
		reset_n_i <= 1'b1;
		bus(1'b0, 8'h00, 8'h00);
		chk("read after reset", q[5:0], 32'h1);
		$display("mid-run reset done");
		wrap_up();
	end
endmodule
